// [hw/bmx_execute_unit.sv]
// Branch / multiply execute unit: a Wishbone slave that runs one selected
// operation on its operands, then updates program counter, flags and the
// product register pair after the operation's own cycle cost.
// Assumes one 20 MHz clock, synchronous bus inputs and one request at a time.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module bmx_execute_unit
   import bmx_pkg::*;
(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Wishbone slave
   input  wire bmx_wb_req_type wbReq,
   output bmx_wb_rsp_type      wbRsp,
   // Core state views
   output logic [15:0]         pcOut,
   output logic [7:0]          flagsOut,
   output logic                busy
);

   // ==========================================================
   // State machine
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } bmx_state_type;

   bmx_state_type state_r, state_nxt;

   // Software visible registers
   logic [15:0] ctrl_r;
   logic [15:0] opnd_r;
   logic [15:0] target_r;
   logic [15:0] pc_r;
   logic [7:0]  flags_r;
   logic [7:0]  result_r;
   logic [15:0] product_r;
   logic [15:0] stack_r;
   logic [2:0]  lastCost_r;
   logic        ack_r;
   logic [31:0] rdData_r;

   // Values held while the operation spends its cycles
   logic [2:0]  cnt_r;
   logic [15:0] pendPc_r;
   logic [7:0]  pendFlags_r;
   logic [7:0]  pendResult_r;
   logic [15:0] pendProd_r;
   logic [15:0] pendStack_r;

   // ==========================================================
   // Functions
   function automatic logic [7:0] laneWrite(input logic [7:0] oldV, input logic [7:0] newV,
                                            input logic en);
      laneWrite = en ? newV : oldV;
   endfunction : laneWrite

   function automatic logic [15:0] relTarget(input logic [15:0] pc, input logic [15:0] k);
      relTarget = 16'(pc + k + 16'h0001);
   endfunction : relTarget

   // ==========================================================
   // Bus decode
   wire         access    = wbReq.cyc & wbReq.stb & ack_r;
   wire         wrAccess  = access & wbReq.we;
   wire         idle      = (state_r == ST_IDLE);
   wire         wrCtrl    = wrAccess & (wbReq.adr == ADR_CTRL) & wbReq.sel[0];
   wire         startOp   = wrCtrl & idle;
   wire [15:0]  ctrlIn    = {laneWrite(ctrl_r[15:8], wbReq.dat[15:8], wbReq.sel[1]),
                             laneWrite(ctrl_r[7:0], wbReq.dat[7:0], wbReq.sel[0])};

   // Operation fields seen at the start of an operation
   wire bmx_op_type op    = bmx_op_type'(ctrlIn[CTRL_OP_LSB +: CTRL_OP_W]);
   wire [2:0]   bitSel    = ctrlIn[CTRL_BIT_LSB +: 3];
   wire         twoWord   = ctrlIn[CTRL_TWO_POS];
   wire [7:0]   rd        = opnd_r[7:0];
   wire [7:0]   rr        = opnd_r[15:8];

   // ==========================================================
   // Arithmetic shared by compares and multiplies
   wire         cinUse    = (op == OP_CMP_CIN) & flags_r[FL_C];
   wire [7:0]   diff      = 8'(rd - rr - {7'h00, cinUse});
   wire         subH      = (~rd[3] & rr[3]) | (rr[3] & diff[3]) | (diff[3] & ~rd[3]);
   wire         subV      = (rd[7] & ~rr[7] & ~diff[7]) | (~rd[7] & rr[7] & diff[7]);
   wire         subC      = (~rd[7] & rr[7]) | (rr[7] & diff[7]) | (diff[7] & ~rd[7]);
   wire         signA     = (op == OP_SMUL) | (op == OP_SUMUL) |
                            (op == OP_FSMUL) | (op == OP_FSUMUL);
   wire         signB     = (op == OP_SMUL) | (op == OP_FSMUL);
   wire [17:0]  prodWide  = 18'($signed({signA & rd[7], rd}) * $signed({signB & rr[7], rr}));
   wire [15:0]  prod      = prodWide[15:0];
   wire         fracOp    = (op == OP_FUMUL) | (op == OP_FSMUL) | (op == OP_FSUMUL);
   wire [15:0]  prodOut   = fracOp ? {prod[14:0], 1'b0} : prod;

   // Skip length and skip cost
   wire [15:0]  skipPc    = 16'(pc_r + (twoWord ? 16'h0003 : 16'h0002));
   wire [2:0]   skipCost  = twoWord ? COST_THREE : COST_TWO;
   wire [15:0]  nextPc    = 16'(pc_r + 16'h0001);
   wire [15:0]  brPc      = relTarget(pc_r, target_r);

   // ==========================================================
   // Operation effects
   logic [15:0] calcPc;
   logic [7:0]  calcFlags;
   logic [7:0]  calcResult;
   logic [15:0] calcProd;
   logic [15:0] calcStack;
   logic [2:0]  calcCost;
   logic        cond;
   logic        isBranch;
   logic        isSkip;

   // Branch and skip conditions
   always_comb begin
      cond     = 1'b0;
      isBranch = 1'b1;
      isSkip   = 1'b0;
      case (op)
         OP_EQ_SKIP:   begin cond = (rd == rr); isSkip = 1'b1; isBranch = 1'b0; end
         OP_RB_CLR_SK: begin cond = ~rr[bitSel]; isSkip = 1'b1; isBranch = 1'b0; end
         OP_RB_SET_SK: begin cond = rr[bitSel]; isSkip = 1'b1; isBranch = 1'b0; end
         OP_IO_CLR_SK: begin cond = ~rr[bitSel]; isSkip = 1'b1; isBranch = 1'b0; end
         OP_IO_SET_SK: begin cond = rr[bitSel]; isSkip = 1'b1; isBranch = 1'b0; end
         OP_SB_SET_BR: cond = flags_r[bitSel];
         OP_SB_CLR_BR: cond = ~flags_r[bitSel];
         OP_EQ_BR:     cond = flags_r[FL_Z];
         OP_NE_BR:     cond = ~flags_r[FL_Z];
         OP_CS_BR,
         OP_LO_BR:     cond = flags_r[FL_C];
         OP_CC_BR,
         OP_SH_BR:     cond = ~flags_r[FL_C];
         OP_MI_BR:     cond = flags_r[FL_N];
         OP_PL_BR:     cond = ~flags_r[FL_N];
         OP_GE_BR:     cond = ~(flags_r[FL_N] ^ flags_r[FL_V]);
         OP_LT_BR:     cond = flags_r[FL_N] ^ flags_r[FL_V];
         OP_HS_BR:     cond = flags_r[FL_H];
         OP_HC_BR:     cond = ~flags_r[FL_H];
         OP_TS_BR:     cond = flags_r[FL_T];
         OP_TC_BR:     cond = ~flags_r[FL_T];
         OP_VS_BR:     cond = flags_r[FL_V];
         default:      isBranch = 1'b0;
      endcase
   end

   // New program counter, flags, results and cost
   always_comb begin
      calcPc     = nextPc;
      calcFlags  = flags_r;
      calcResult = result_r;
      calcProd   = product_r;
      calcStack  = stack_r;
      calcCost   = COST_ONE;
      if (isBranch) begin
         calcPc   = cond ? brPc : nextPc;
         calcCost = cond ? COST_TWO : COST_ONE;
      end else if (isSkip) begin
         calcPc   = cond ? skipPc : nextPc;
         calcCost = cond ? skipCost : COST_ONE;
      end
      case (op)
         OP_SELF_AND, OP_XOR_ZERO: begin
            calcResult       = (op == OP_SELF_AND) ? (rd & rd) : (rd ^ rd);
            calcFlags[FL_Z]  = (calcResult == 8'h00);
            calcFlags[FL_N]  = calcResult[7];
            calcFlags[FL_V]  = 1'b0;
         end
         OP_ALL_ONES: calcResult = 8'hFF;
         OP_UMUL, OP_SMUL, OP_SUMUL, OP_FUMUL, OP_FSMUL, OP_FSUMUL: begin
            calcProd         = prodOut;
            calcFlags[FL_Z]  = (prodOut == 16'h0000);
            calcFlags[FL_C]  = prod[15];
            calcCost         = COST_TWO;
         end
         OP_REL_JUMP: begin calcPc = brPc; calcCost = COST_TWO; end
         OP_IND_JUMP: begin calcPc = target_r; calcCost = COST_TWO; end
         OP_ABS_JUMP: begin calcPc = target_r; calcCost = COST_THREE; end
         OP_REL_CALL: begin
            calcPc    = brPc;
            calcStack = nextPc;
            calcCost  = COST_THREE;
         end
         OP_IND_CALL: begin
            calcPc    = target_r;
            calcStack = nextPc;
            calcCost  = COST_THREE;
         end
         OP_ABS_CALL: begin
            calcPc    = target_r;
            calcStack = 16'(pc_r + 16'h0002);                // Two-word call
            calcCost  = COST_FOUR;
         end
         OP_SUB_EXIT, OP_INT_EXIT: begin
            calcPc    = stack_r;
            calcCost  = COST_FOUR;
            if (op == OP_INT_EXIT) begin
               calcFlags[FL_I] = 1'b1;
            end
         end
         OP_CMP, OP_CMP_CIN, OP_CMP_IMM: begin
            calcFlags[FL_Z] = (op == OP_CMP_CIN) ? ((diff == 8'h00) & flags_r[FL_Z])
                                                 : (diff == 8'h00);
            calcFlags[FL_N] = diff[7];
            calcFlags[FL_V] = subV;
            calcFlags[FL_C] = subC;
            calcFlags[FL_H] = subH;
            calcFlags[FL_S] = diff[7] ^ subV;
         end
         default: ;
      endcase
   end

   // ==========================================================
   // Sequencing of the cycle cost
   wire finish = (state_r == ST_EXEC) & (cnt_r == COST_ONE);

   always_comb begin
      case (state_r)
         ST_IDLE: state_nxt = startOp ? ST_EXEC : ST_IDLE;
         ST_EXEC: state_nxt = finish ? ST_IDLE : ST_EXEC;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State, counter and held effects
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r      <= ST_IDLE;
         cnt_r        <= 3'h0;
         lastCost_r   <= 3'h0;
         pendPc_r     <= PC_RESET;
         pendFlags_r  <= FLAGS_RESET;
         pendResult_r <= 8'h00;
         pendProd_r   <= 16'h0000;
         pendStack_r  <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         if (startOp) begin
            cnt_r        <= calcCost;
            lastCost_r   <= calcCost;
            pendPc_r     <= calcPc;
            pendFlags_r  <= calcFlags;
            pendResult_r <= calcResult;
            pendProd_r   <= calcProd;
            pendStack_r  <= calcStack;
         end else if (state_r == ST_EXEC) begin
            cnt_r <= 3'(cnt_r - COST_ONE);
         end
      end
   end

   // ==========================================================
   // Register writes from the bus and commits from the sequencer
   wire wrPc    = wrAccess & (wbReq.adr == ADR_PC) & idle;
   wire wrFlags = wrAccess & (wbReq.adr == ADR_FLAGS) & idle & wbReq.sel[0];
   wire wrStack = wrAccess & (wbReq.adr == ADR_STACK) & idle;
   wire wrOpnd  = wrAccess & (wbReq.adr == ADR_OPND) & idle;
   wire wrTgt   = wrAccess & (wbReq.adr == ADR_TARGET) & idle;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r    <= 16'h0000;
         opnd_r    <= 16'h0000;
         target_r  <= 16'h0000;
         pc_r      <= PC_RESET;
         flags_r   <= FLAGS_RESET;
         result_r  <= 8'h00;
         product_r <= 16'h0000;
         stack_r   <= 16'h0000;
      end else begin
         if (startOp) ctrl_r <= ctrlIn;
         if (wrOpnd) opnd_r <= {laneWrite(opnd_r[15:8], wbReq.dat[15:8], wbReq.sel[1]),
                                laneWrite(opnd_r[7:0], wbReq.dat[7:0], wbReq.sel[0])};
         if (wrTgt) target_r <= {laneWrite(target_r[15:8], wbReq.dat[15:8], wbReq.sel[1]),
                                 laneWrite(target_r[7:0], wbReq.dat[7:0], wbReq.sel[0])};
         if (finish) begin
            pc_r      <= pendPc_r;
            flags_r   <= pendFlags_r;
            result_r  <= pendResult_r;
            product_r <= pendProd_r;
            stack_r   <= pendStack_r;
         end else begin
            if (wrPc) pc_r <= {laneWrite(pc_r[15:8], wbReq.dat[15:8], wbReq.sel[1]),
                               laneWrite(pc_r[7:0], wbReq.dat[7:0], wbReq.sel[0])};
            if (wrFlags) flags_r <= wbReq.dat[7:0];
            if (wrStack) stack_r <= {laneWrite(stack_r[15:8], wbReq.dat[15:8], wbReq.sel[1]),
                                     laneWrite(stack_r[7:0], wbReq.dat[7:0], wbReq.sel[0])};
         end
      end
   end

   // ==========================================================
   // Read mux; unmapped offsets read zero and still acknowledge
   logic [31:0] rdMux;

   always_comb begin
      case (wbReq.adr)
         ADR_CTRL:   rdMux = {16'h0000, ctrl_r};
         ADR_OPND:   rdMux = {16'h0000, opnd_r};
         ADR_TARGET: rdMux = {16'h0000, target_r};
         ADR_PC:     rdMux = {16'h0000, pc_r};
         ADR_FLAGS:  rdMux = {24'h000000, flags_r};
         ADR_RESULT: rdMux = {product_r, 8'h00, result_r};
         ADR_STATUS: rdMux = {28'h0000000, lastCost_r, ~idle};
         ADR_STACK:  rdMux = {16'h0000, stack_r};
         default:    rdMux = 32'h00000000;
      endcase
   end

   // Acknowledge one cycle after the request, drop it the next
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r    <= 1'b0;
         rdData_r <= 32'h00000000;
      end else begin
         ack_r    <= wbReq.cyc & wbReq.stb & ~ack_r;
         rdData_r <= rdMux;
      end
   end

   assign wbRsp.ack = ack_r;
   assign wbRsp.dat = rdData_r;
   assign pcOut     = pc_r;
   assign flagsOut  = flags_r;
   assign busy      = ~idle;

   // ==========================================================
   // Checks
   self_test_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_SELF_AND |-> ##2 flags_r[FL_Z] == ($past(rd, 2) == 8'h00)
         && flags_r[FL_V] == 1'b0 && result_r == $past(rd, 2))
      else $error("self test result or flags wrong");

   all_ones_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_ALL_ONES |-> ##2 result_r == 8'hFF && $stable(flags_r))
      else $error("all ones load wrong");

   mul_timing_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_UMUL |=> busy [*2] ##1 !busy
         && product_r == 16'($past(rd, 3) * $past(rr, 3)))
      else $error("unsigned product wrong or late");

   frac_shift_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_FUMUL |-> ##3 product_r == 16'(16'($past(rd, 3) * $past(rr, 3))
         << 1))
      else $error("fractional product not shifted");

   abs_jump_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_ABS_JUMP |=> busy [*3] ##1 pc_r == $past(target_r, 4))
      else $error("absolute jump cost or target wrong");

   exit_cost_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_INT_EXIT |-> ##5 pc_r == $past(stack_r, 5) && flags_r[FL_I])
      else $error("interrupt exit wrong");

   skip_len_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_EQ_SKIP && rd == rr && !twoWord |-> ##3
         pc_r == 16'($past(pc_r, 3) + 16'h0002))
      else $error("equal skip target wrong");

   cmp_carry_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_CMP |-> ##2 flags_r[FL_C] == ($past(rd, 2) < $past(rr, 2))
         && result_r == $past(result_r, 2))
      else $error("compare carry wrong");

   branch_cost_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && isBranch && !cond |=> busy ##1 !busy && pc_r == $past(nextPc, 2))
      else $error("untaken branch not one cycle");

   signed_ge_a: assert property (@(posedge clk) disable iff (!rst_b)
      startOp && op == OP_GE_BR && !(flags_r[FL_N] ^ flags_r[FL_V]) |-> ##3
         pc_r == $past(brPc, 3))
      else $error("signed branch not taken");

endmodule : bmx_execute_unit

`default_nettype wire

// [shared/bmx_pkg.sv]
// Package for the branch / multiply execute unit: register map, field
// positions, operation codes, flag positions and bus carrier types.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package bmx_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] ADR_CTRL   = 8'h00;  // Operation select, write starts
   localparam logic [7:0] ADR_OPND   = 8'h04;  // Two byte operands
   localparam logic [7:0] ADR_TARGET = 8'h08;  // Offset, address or Z pointer
   localparam logic [7:0] ADR_PC     = 8'h0C;  // Program counter
   localparam logic [7:0] ADR_FLAGS  = 8'h10;  // Flag register
   localparam logic [7:0] ADR_RESULT = 8'h14;  // Result byte and product pair
   localparam logic [7:0] ADR_STATUS = 8'h18;  // Busy and last cost
   localparam logic [7:0] ADR_STACK  = 8'h1C;  // Stack top word

   // ==========================================================
   // Control field positions
   localparam int CTRL_OP_LSB  = 0;
   localparam int CTRL_OP_W    = 6;
   localparam int CTRL_BIT_LSB = 8;
   localparam int CTRL_TWO_POS = 12;  // Following instruction is two words
   localparam int RES_PROD_LSB = 16;

   // ==========================================================
   // Flag bit positions
   localparam int FL_C = 0;
   localparam int FL_Z = 1;
   localparam int FL_N = 2;
   localparam int FL_V = 3;
   localparam int FL_S = 4;
   localparam int FL_H = 5;
   localparam int FL_T = 6;
   localparam int FL_I = 7;

   // ==========================================================
   // Reset values and cycle costs
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [2:0]  COST_ONE    = 3'h1;
   localparam logic [2:0]  COST_TWO    = 3'h2;
   localparam logic [2:0]  COST_THREE  = 3'h3;
   localparam logic [2:0]  COST_FOUR   = 3'h4;

   // ==========================================================
   // Operation codes
   typedef enum logic [5:0] {
      OP_NONE     = 6'h00, OP_SELF_AND  = 6'h01, OP_XOR_ZERO  = 6'h02,
      OP_ALL_ONES = 6'h03, OP_UMUL      = 6'h04, OP_SMUL      = 6'h05,
      OP_SUMUL    = 6'h06, OP_FUMUL     = 6'h07, OP_FSMUL     = 6'h08,
      OP_FSUMUL   = 6'h09, OP_REL_JUMP  = 6'h0A, OP_IND_JUMP  = 6'h0B,
      OP_ABS_JUMP = 6'h0C, OP_REL_CALL  = 6'h0D, OP_IND_CALL  = 6'h0E,
      OP_ABS_CALL = 6'h0F, OP_SUB_EXIT  = 6'h10, OP_INT_EXIT  = 6'h11,
      OP_EQ_SKIP  = 6'h12, OP_CMP       = 6'h13, OP_CMP_CIN   = 6'h14,
      OP_CMP_IMM  = 6'h15, OP_RB_CLR_SK = 6'h16, OP_RB_SET_SK = 6'h17,
      OP_IO_CLR_SK = 6'h18, OP_IO_SET_SK = 6'h19, OP_SB_SET_BR = 6'h1A,
      OP_SB_CLR_BR = 6'h1B, OP_EQ_BR    = 6'h1C, OP_NE_BR     = 6'h1D,
      OP_CS_BR    = 6'h1E, OP_CC_BR     = 6'h1F, OP_SH_BR     = 6'h20,
      OP_LO_BR    = 6'h21, OP_MI_BR     = 6'h22, OP_PL_BR     = 6'h23,
      OP_GE_BR    = 6'h24, OP_LT_BR     = 6'h25, OP_HS_BR     = 6'h26,
      OP_HC_BR    = 6'h27, OP_TS_BR     = 6'h28, OP_TC_BR     = 6'h29,
      OP_VS_BR    = 6'h2A
   } bmx_op_type;

   // ==========================================================
   // Wishbone carriers
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } bmx_wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } bmx_wb_rsp_type;

endpackage : bmx_pkg

// [tb/tb.sv]
// Self-checking bench for the branch / multiply execute unit.
// Assumes the unit's Wishbone register map and one-cycle acks.
`timescale 1ns/1ps
`default_nettype none

module tb import bmx_pkg::*;;
   // ==========================================================
   // Signals
   logic           clk;
   logic           rst_b;
   bmx_wb_req_type wbReq;
   bmx_wb_rsp_type wbRsp;
   logic [15:0]    pcOut;
   logic [7:0]     flagsOut;
   logic           busy;
   int             num_errors;
   int             n_tests;
   logic [31:0]    rdq;
   logic [15:0]    brTab [17];
   bmx_op_type     brOp [17];

   // Clock, 50 ns period
   always #25 clk = ~clk;

   bmx_execute_unit dut (.clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbRsp(wbRsp),
                         .pcOut(pcOut), .flagsOut(flagsOut), .busy(busy));

   // ==========================================================
   // Verdict, compare and bus tasks
   task automatic test_done;
      $display("errors %0d compares %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      n_tests++;
      if ((got & m) !== (exp & m)) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got & m, exp & m);
      end
   endtask : chk

   // One classic cycle, held until ack is sampled
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge clk);
         n++;
      end while (wbRsp.ack !== 1'b1 && n < 20);
      if (n >= 20)
         chk(32'h0, 32'h1, 32'h1);  // Missing ack
      rdq = wbRsp.dat;
      wbReq <= '0;
      @(posedge clk);
   endtask : xfer

   // Load state, start op, poll busy, check cost, PC, flags, result
   task automatic run(input bmx_op_type op, input logic [15:0] opnd, tgt, pcIn,
                      input logic [7:0] fl, input logic [3:0] x, input logic [15:0] ePc, pm,
                      input logic [7:0] ef, input logic [31:0] res, rm, input logic [2:0] cost);
      int n;
      xfer(1'b1, ADR_OPND, {16'h0, opnd});
      xfer(1'b1, ADR_TARGET, {16'h0, tgt});
      xfer(1'b1, ADR_PC, {16'h0, pcIn});
      xfer(1'b1, ADR_FLAGS, {24'h0, fl});
      xfer(1'b1, ADR_STACK, {16'h0, tgt});
      xfer(1'b1, ADR_CTRL, {19'h0, x[3], 1'b0, x[2:0], 2'b0, op});
      if (cost == COST_FOUR)
         xfer(1'b1, ADR_PC, 32'h0000DEAD);  // Refused while busy
      n = 0;
      do begin
         xfer(1'b0, ADR_STATUS, 32'h0);
         n++;
      end while (rdq[0] !== 1'b0 && n < 20);
      chk({28'h0, rdq[3:0]}, {28'h0, cost, 1'b0}, 32'hF);
      chk({16'h0, pcOut}, {16'h0, ePc}, {16'h0, pm});
      chk({24'h0, flagsOut}, {24'h0, ef}, 32'hFF);
      xfer(1'b0, ADR_RESULT, 32'h0);
      chk(rdq, res, rm);
      if (op inside {OP_REL_CALL, OP_IND_CALL, OP_ABS_CALL}) begin
         xfer(1'b0, ADR_STACK, 32'h0);
         chk(rdq, {16'h0, pcIn + ((op == OP_ABS_CALL) ? 16'h2 : 16'h1)}, 32'hFFFF);
      end
   endtask : run

   task automatic fop(input bmx_op_type op, input logic [15:0] opnd, input logic [7:0] fl, ef,
                      input logic [31:0] res, rm, input logic [2:0] cost);
      run(op, opnd, 16'h0, 16'h0, fl, 4'h0, 16'h0001, 16'hFFFF, ef, res, rm, cost);
   endtask : fop

   task automatic jop(input bmx_op_type op, input logic [15:0] opnd, tgt, pcIn,
                      input logic [7:0] fl, input logic [3:0] x, input logic [15:0] ePc,
                      input logic [2:0] cost);
      run(op, opnd, tgt, pcIn, fl, x, ePc, 16'hFFFF, (op == OP_INT_EXIT) ? (fl | 8'h80) : fl,
          32'h0, 32'h0, cost);
   endtask : jop

   // ==========================================================
   // Watchdog
   initial begin
      #2000000;
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end

   // ==========================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      wbReq = '0;
      num_errors = 0;
      n_tests = 0;
      brOp = '{OP_EQ_BR, OP_NE_BR, OP_CS_BR, OP_CC_BR, OP_SH_BR, OP_LO_BR, OP_MI_BR,
               OP_PL_BR, OP_GE_BR, OP_LT_BR, OP_HS_BR, OP_HC_BR, OP_TS_BR, OP_TC_BR,
               OP_VS_BR, OP_SB_SET_BR, OP_SB_CLR_BR};
      brTab = '{16'h0200, 16'h0002, 16'h0100, 16'h0001, 16'h0001, 16'h0100, 16'h0400,
                16'h0004, 16'h0C04, 16'h080C, 16'h2000, 16'h0020, 16'h4000, 16'h0040,
                16'h0800, 16'h4000, 16'h0040};
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk({pcOut, flagsOut, 7'h0, busy}, {PC_RESET, FLAGS_RESET, 8'h0}, 32'hFFFFFFFF);
      xfer(1'b0, 8'h20, 32'h0);
      chk(rdq, 32'h0, 32'hFFFFFFFF);
      fop(OP_SELF_AND, 16'h0080, 8'h09, 8'h05, 32'h80, 32'hFF, COST_ONE);
      fop(OP_XOR_ZERO, 16'h0055, 8'h04, 8'h02, 32'h00, 32'hFF, COST_ONE);
      fop(OP_ALL_ONES, 16'h0012, 8'h2B, 8'h2B, 32'hFF, 32'hFF, COST_ONE);
      fop(OP_UMUL, 16'hFFFF, 8'h02, 8'h01, 32'hFE010000, 32'hFFFF0000, COST_TWO);
      fop(OP_UMUL, 16'h1200, 8'h00, 8'h02, 32'h00000000, 32'hFFFF0000, COST_TWO);
      fop(OP_SMUL, 16'h01FF, 8'h00, 8'h01, 32'hFFFF0000, 32'hFFFF0000, COST_TWO);
      fop(OP_SUMUL, 16'h03FE, 8'h00, 8'h01, 32'hFFFA0000, 32'hFFFF0000, COST_TWO);
      fop(OP_FUMUL, 16'h8080, 8'h03, 8'h00, 32'h80000000, 32'hFFFF0000, COST_TWO);
      fop(OP_FSMUL, 16'h8080, 8'h00, 8'h00, 32'h80000000, 32'hFFFF0000, COST_TWO);
      fop(OP_FSUMUL, 16'h02FF, 8'h00, 8'h01, 32'hFFFC0000, 32'hFFFF0000, COST_TWO);
      fop(OP_CMP, 16'h2010, 8'h00, 8'h15, 32'h0, 32'h0, COST_ONE);
      fop(OP_CMP_CIN, 16'h0505, 8'h02, 8'h02, 32'h0, 32'h0, COST_ONE);
      fop(OP_CMP_CIN, 16'h0505, 8'h03, 8'h35, 32'h0, 32'h0, COST_ONE);
      fop(OP_CMP_IMM, 16'h0180, 8'h00, 8'h38, 32'h0, 32'h0, COST_ONE);
      jop(OP_REL_JUMP, 16'h0, 16'hFFFE, 16'h0010, 8'h00, 4'h0, 16'h000F, COST_TWO);
      jop(OP_IND_JUMP, 16'h0, 16'h1234, 16'h0000, 8'h00, 4'h0, 16'h1234, COST_TWO);
      jop(OP_ABS_JUMP, 16'h0, 16'h0ABC, 16'h0000, 8'h00, 4'h0, 16'h0ABC, COST_THREE);
      jop(OP_REL_CALL, 16'h0, 16'h0005, 16'h0020, 8'h00, 4'h0, 16'h0026, COST_THREE);
      jop(OP_IND_CALL, 16'h0, 16'h0777, 16'h0020, 8'h00, 4'h0, 16'h0777, COST_THREE);
      jop(OP_ABS_CALL, 16'h0, 16'h1F00, 16'h0030, 8'h00, 4'h0, 16'h1F00, COST_FOUR);
      jop(OP_SUB_EXIT, 16'h0, 16'h0345, 16'h0030, 8'h00, 4'h0, 16'h0345, COST_FOUR);
      jop(OP_INT_EXIT, 16'h0, 16'h0456, 16'h0030, 8'h00, 4'h0, 16'h0456, COST_FOUR);
      jop(OP_EQ_SKIP, 16'h0505, 16'h0, 16'h0040, 8'h00, 4'h8, 16'h0043, COST_THREE);
      jop(OP_EQ_SKIP, 16'h0605, 16'h0, 16'h0040, 8'h00, 4'h0, 16'h0041, COST_ONE);
      jop(OP_EQ_SKIP, 16'h0707, 16'h0, 16'h0040, 8'h00, 4'h0, 16'h0042, COST_TWO);
      jop(OP_RB_SET_SK, 16'h0808, 16'h0, 16'h0040, 8'h00, 4'h3, 16'h0042, COST_TWO);
      jop(OP_RB_CLR_SK, 16'h0808, 16'h0, 16'h0040, 8'h00, 4'h3, 16'h0041, COST_ONE);
      jop(OP_RB_CLR_SK, 16'h0000, 16'h0, 16'h0040, 8'h00, 4'hB, 16'h0043, COST_THREE);
      jop(OP_IO_CLR_SK, 16'h0808, 16'h0, 16'h0040, 8'h00, 4'h3, 16'h0041, COST_ONE);
      jop(OP_IO_SET_SK, 16'h0808, 16'h0, 16'h0040, 8'h00, 4'h3, 16'h0042, COST_TWO);
      for (int i = 0; i < 17; i++) begin
         jop(brOp[i], 16'h0, 16'hFFF0, 16'h0100, brTab[i][15:8], 4'h6, 16'h00F1,
             COST_TWO);
         jop(brOp[i], 16'h0, 16'hFFF0, 16'h0100, brTab[i][7:0], 4'h6, 16'h0101,
             COST_ONE);
      end
      test_done();
   end
endmodule : tb

`default_nettype wire
